// ===== dacc_pkg.sv
// Constants, field layout and types of the accumulator saturation and round back end
package dacc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] TRAP_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] WBPTR_OFS = 4'hc;
  localparam int CFG_SAT_A_BIT = 7;
  localparam int CFG_SAT_B_BIT = 6;
  localparam int CFG_WR_SAT_BIT = 5;
  localparam int CFG_WIDTH_BIT = 4;
  localparam int CFG_RND_BIT = 1;
  localparam int TRP_OVA_BIT = 0;
  localparam int TRP_OVB_BIT = 1;
  localparam int TRP_COV_BIT = 2;
  localparam int ST_OVA_BIT = 0;
  localparam int ST_OVB_BIT = 1;
  localparam int ST_ACC_A_SAT_EN_BIT = 2;
  localparam int ST_ACC_B_SAT_EN_BIT = 3;
  localparam int ST_ANYOV_BIT = 4;
  localparam int ST_ANYSAT_BIT = 5;
  localparam logic [39:0] SAT32_POS = 40'h007fffffff;
  localparam logic [39:0] SAT32_NEG = 40'hff80000000;
  localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
  localparam logic [39:0] SAT40_NEG = 40'h8000000000;
  localparam logic [15:0] HALF_LSW = 16'h8000;
  localparam logic [15:0] W_POS = 16'h7fff;
  localparam logic [15:0] W_NEG = 16'h8000;
  localparam logic [15:0] WB_STEP = 16'h0002;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    DACC_ST_SAC = 3'b001,
    DACC_ST_WB_DIRECT = 3'b010,
    DACC_ST_WB_INDIRECT = 3'b100
  } dacc_st_kind_t;
  typedef enum logic [2:0] {
    DACC_SH_ACC_A = 3'b001,
    DACC_SH_ACC_B = 3'b010,
    DACC_SH_XBUS = 3'b100
  } dacc_sh_src_t;
endpackage

// ===== dacc_engine.sv
// Accumulator back end: adder status and saturation, round, write saturation, shifter
`timescale 1ns/1ps
module dacc_engine (
  input wire logic aclk, // 125 MHz core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [dacc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [dacc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic add_valid, // One adder pass this cycle
  input wire logic add_target, // 0 accumulator A, 1 accumulator B
  input wire logic [39:0] add_operand, // Sign-extended operand
  input wire logic add_negate, // Subtract operand instead of add
  input wire logic add_zero, // Zero the accumulator input (load)
  input wire logic st_valid, // Store request
  input wire dacc_pkg::dacc_st_kind_t st_kind, // Store or write-back mode
  input wire logic st_target, // Store source, or write-back target accumulator
  input wire logic st_round, // Round a plain store
  input wire logic [15:0] st_addr, // Address of a plain store
  input wire logic sh_valid, // Shift request
  input wire dacc_pkg::dacc_sh_src_t sh_src, // Shift source
  input wire logic [15:0] sh_xdata, // X bus operand
  input wire logic signed [4:0] sh_amount, // Positive right, negative left
  input wire logic sh_arith, // Arithmetic right shift
  output logic [39:0] acc_a, // Accumulator A
  output logic [39:0] acc_b, // Accumulator B
  output logic xbus_wr_valid, // Data-space write pulse
  output logic [15:0] xbus_wr_addr, // Data-space write address
  output logic [15:0] xbus_wr_data, // Data-space write data
  output logic [15:0] wb_ptr, // Write-back pointer register
  output logic sh_done, // Shift result valid pulse
  output logic [39:0] sh_result, // 40-bit shift result
  output logic [15:0] sh_word, // 16-bit result of an X bus shift
  output logic trap_req // Arithmetic warning trap request
);
  import dacc_pkg::*;

  logic [7:0] core_config_reg;
  logic [2:0] trap_control_reg;
  logic acc_a_guard_ovf, acc_b_guard_ovf, acc_a_sat_flag, acc_b_sat_flag;
  logic any_guard_ovf, any_sat_flag;
  logic acc_a_sat_en, acc_b_sat_en, sat_width_sel, write_sat_en, round_style_sel;
  logic acc_a_ovf_trap_en, acc_b_ovf_trap_en, catastrophic_trap_en;

  assign acc_a_sat_en = core_config_reg[CFG_SAT_A_BIT];
  assign acc_b_sat_en = core_config_reg[CFG_SAT_B_BIT];
  assign sat_width_sel = core_config_reg[CFG_WIDTH_BIT];
  assign write_sat_en = core_config_reg[CFG_WR_SAT_BIT];
  assign round_style_sel = core_config_reg[CFG_RND_BIT];
  assign acc_a_ovf_trap_en = trap_control_reg[TRP_OVA_BIT];
  assign acc_b_ovf_trap_en = trap_control_reg[TRP_OVB_BIT];
  assign catastrophic_trap_en = trap_control_reg[TRP_COV_BIT];
  assign any_guard_ovf = acc_a_guard_ovf | acc_b_guard_ovf;
  assign any_sat_flag = acc_a_sat_flag | acc_b_sat_flag;

  // AXI4-Lite slave: address and data may arrive in either order
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic clr_sat_a, clr_sat_b, sw_wbptr_wr;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign clr_sat_a = do_write && aw_addr == STATUS_OFS && w_strb[0] && w_data[ST_ACC_A_SAT_EN_BIT];
  assign clr_sat_b = do_write && aw_addr == STATUS_OFS && w_strb[0] && w_data[ST_ACC_B_SAT_EN_BIT];
  assign sw_wbptr_wr = do_write && aw_addr == WBPTR_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == CONFIG_OFS || aw_addr == TRAP_OFS ||
                        aw_addr == STATUS_OFS || aw_addr == WBPTR_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_config_reg <= '0;
      trap_control_reg <= '0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == CONFIG_OFS) core_config_reg <= w_data[7:0];
      if (aw_addr == TRAP_OFS) trap_control_reg <= w_data[2:0];
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        CONFIG_OFS: s_axi_rdata <= {24'h0, core_config_reg};
        TRAP_OFS: s_axi_rdata <= {29'h0, trap_control_reg};
        STATUS_OFS: s_axi_rdata <= {26'h0, any_sat_flag, any_guard_ovf, acc_b_sat_flag,
                                    acc_a_sat_flag, acc_b_guard_ovf, acc_a_guard_ovf};
        WBPTR_OFS: s_axi_rdata <= {16'h0, wb_ptr};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Adder pass with overflow detection and saturation
  logic [40:0] opx, base, sum;
  logic [39:0] next_acc;
  logic sat_en, ovf39, ovf32, sat_event, next_guard;

  always_comb begin
    opx = {add_operand[39], add_operand};
    base = add_zero ? 41'h0 : (add_target ? {acc_b[39], acc_b} : {acc_a[39], acc_a});
    sum = base + (add_negate ? 41'h0 - opx : opx);
    sat_en = add_target ? acc_b_sat_en : acc_a_sat_en;
    ovf39 = sum[40] ^ sum[39];
    ovf32 = !(&sum[40:31] || !(|sum[40:31]));
    next_acc = sum[39:0];
    sat_event = ovf39;
    if (sat_en && !sat_width_sel) begin
      sat_event = ovf32;
      if (ovf32) next_acc = sum[40] ? SAT32_NEG : SAT32_POS;
    end else if (sat_en) begin
      if (ovf39) next_acc = sum[40] ? SAT40_NEG : SAT40_POS;
    end
    // Guard bits disagree with the 1.31 sign bit
    next_guard = !(&next_acc[39:31] || !(|next_acc[39:31]));
    if (sat_en && !sat_width_sel) next_guard = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_a <= '0;
      acc_b <= '0;
      acc_a_guard_ovf <= 1'b0;
      acc_b_guard_ovf <= 1'b0;
    end else if (add_valid) begin
      if (add_target) begin
        acc_b <= next_acc;
        acc_b_guard_ovf <= next_guard;
      end else begin
        acc_a <= next_acc;
        acc_a_guard_ovf <= next_guard;
      end
    end
  end

  // A new saturation beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_a_sat_flag <= 1'b0;
      acc_b_sat_flag <= 1'b0;
    end else begin
      acc_a_sat_flag <= (acc_a_sat_flag && !clr_sat_a) ||
                        (add_valid && !add_target && sat_event);
      acc_b_sat_flag <= (acc_b_sat_flag && !clr_sat_b) ||
                        (add_valid && add_target && sat_event);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_req <= 1'b0;
    end else begin
      trap_req <= (acc_a_guard_ovf && acc_a_ovf_trap_en) ||
                  (acc_b_guard_ovf && acc_b_ovf_trap_en) ||
                  (catastrophic_trap_en && ((acc_a_sat_flag && !acc_a_sat_en) ||
                                            (acc_b_sat_flag && !acc_b_sat_en)));
    end
  end

  // Round and data-space write saturation; only the written word is clamped
  logic [39:0] st_acc;
  logic st_src, do_round, inc;
  logic [23:0] ext;
  logic [15:0] st_word;

  always_comb begin
    st_src = (st_kind == DACC_ST_SAC) ? st_target : !st_target;
    st_acc = st_src ? acc_b : acc_a;
    do_round = (st_kind == DACC_ST_SAC) ? st_round : 1'b1;
    inc = st_acc[15];
    if (round_style_sel && st_acc[15:0] == HALF_LSW) inc = st_acc[16];
    if (!do_round) inc = 1'b0;
    ext = st_acc[39:16] + {23'h0, inc};
    st_word = ext[15:0];
    if (write_sat_en) begin
      if (!st_acc[39] && ext[23:15] != 9'h000) st_word = W_POS;
      // Rounding minus one LSB up carries out to zero, which is in range
      if (st_acc[39] && ext[23] && ext[23:15] != 9'h1ff) st_word = W_NEG;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xbus_wr_valid <= 1'b0;
      xbus_wr_addr <= '0;
      xbus_wr_data <= '0;
    end else begin
      xbus_wr_valid <= st_valid && st_kind != DACC_ST_WB_DIRECT;
      if (st_valid) begin
        xbus_wr_addr <= (st_kind == DACC_ST_SAC) ? st_addr : wb_ptr;
        xbus_wr_data <= st_word;
      end
    end
  end

  // Hardware write-back beats a software write to the pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_ptr <= '0;
    end else if (st_valid && st_kind == DACC_ST_WB_DIRECT) begin
      wb_ptr <= st_word;
    end else if (st_valid && st_kind == DACC_ST_WB_INDIRECT) begin
      wb_ptr <= wb_ptr + WB_STEP;
    end else if (sw_wbptr_wr) begin
      if (w_strb[0]) wb_ptr[7:0] <= w_data[7:0];
      if (w_strb[1]) wb_ptr[15:8] <= w_data[15:8];
    end
  end

  // Barrel shifter, one cycle
  logic [39:0] sh_in, sh_out;
  logic [4:0] sh_left;

  always_comb begin
    sh_left = 5'h0 - sh_amount;
    case (sh_src)
      DACC_SH_ACC_A: sh_in = acc_a;
      DACC_SH_ACC_B: sh_in = acc_b;
      DACC_SH_XBUS: begin
        if (sh_amount > 0) begin
          sh_in = {{8{sh_arith & sh_xdata[15]}}, sh_xdata, 16'h0};
        end else begin
          sh_in = {24'h0, sh_xdata};
        end
      end
      default: sh_in = '0;
    endcase
    if (sh_amount > 0) begin
      if (sh_arith) sh_out = $unsigned($signed(sh_in) >>> sh_amount);
      else sh_out = sh_in >> sh_amount;
    end else begin
      sh_out = sh_in << sh_left;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_done <= 1'b0;
      sh_result <= '0;
      sh_word <= '0;
    end else begin
      sh_done <= sh_valid;
      if (sh_valid) begin
        sh_result <= sh_out;
        sh_word <= (sh_amount > 0) ? sh_out[31:16] : sh_out[15:0];
      end
    end
  end

  default clocking dacc_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_sat_flag_sticky: assert property (acc_a_sat_flag && !clr_sat_a |=> acc_a_sat_flag)
    else $error("saturation flag A dropped without a clear");
  a_sat32_limit: assert property (add_valid && !add_target && acc_a_sat_en && !sat_width_sel
      && ovf32 |=> (acc_a == SAT32_POS || acc_a == SAT32_NEG) && acc_a_sat_flag)
    else $error("32-bit saturation value or flag wrong");
  a_guard_unused32: assert property (add_valid && add_target && acc_b_sat_en
      && !sat_width_sel |=> !acc_b_guard_ovf)
    else $error("guard overflow set in 32-bit saturation");
  a_wrap_catastr: assert property (add_valid && !add_target && !acc_a_sat_en && ovf39
      |=> acc_a_sat_flag && acc_a == $past(sum[39:0]))
    else $error("catastrophic overflow did not wrap and flag");
  a_ovf_trap: assert property (acc_a_guard_ovf && acc_a_ovf_trap_en |=> trap_req)
    else $error("guard overflow trap not raised");
  a_cat_trap: assert property (catastrophic_trap_en && acc_b_sat_flag && !acc_b_sat_en
      |=> trap_req)
    else $error("catastrophic trap not raised");
  a_status_or: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_OFS
      |=> s_axi_rdata[ST_ANYSAT_BIT] == ($past(acc_a_sat_flag) | $past(acc_b_sat_flag)))
    else $error("combined saturation bit wrong");
  a_wbptr_step: assert property (st_valid && st_kind == DACC_ST_WB_INDIRECT
      |=> wb_ptr == $past(wb_ptr) + WB_STEP && xbus_wr_addr == $past(wb_ptr))
    else $error("write-back pointer not stepped by two");
  a_round_conv: assert property (st_valid && st_kind == DACC_ST_SAC && st_round
      && !round_style_sel && !write_sat_en && st_acc[15]
      |=> xbus_wr_data == $past(st_acc[31:16]) + 16'h0001)
    else $error("conventional round did not increment");
  a_wr_sat_pos: assert property (st_valid && write_sat_en && !st_acc[39]
      && ext[23:15] != 9'h000 |=> xbus_wr_data == W_POS && $stable(acc_a))
    else $error("positive write saturation wrong");
  a_shift_zero: assert property (sh_valid && sh_src == DACC_SH_ACC_A && sh_amount == 0
      |=> sh_result == $past(acc_a))
    else $error("zero shift changed the operand");

  c_sat32_hit: cover property (add_valid && acc_a_sat_en && !sat_width_sel && ovf32);
  c_trap_seen: cover property (!trap_req ##1 trap_req);
  c_wb_indirect: cover property (st_valid && st_kind == DACC_ST_WB_INDIRECT);
  c_shift_left: cover property (sh_valid && sh_amount < 0);
endmodule // dacc_engine

// ===== dacc_xmem_model.sv
// Data memory model that takes the X bus writes of the accumulator back end
`timescale 1ns/1ps
module dacc_xmem_model (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic wr_valid, // Write pulse
  input wire logic [15:0] wr_addr, // Word address
  input wire logic [15:0] wr_data, // Word data
  output logic [15:0] last_addr, // Address of the latest write
  output logic [15:0] last_data, // Data of the latest write
  output int wr_count // Writes taken since reset
);
  // Only the latest write is kept, so the bench checks every store as it lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_count <= 0;
    end else if (wr_valid) begin
      last_addr <= wr_addr;
      last_data <= wr_data;
      wr_count <= wr_count + 1;
    end
  end
endmodule // dacc_xmem_model

// ===== dacc_engine_tb_top.sv
// Self-checking bench of the accumulator back end with a data memory on its write bus
`timescale 1ns/1ps
module dacc_engine_tb_top;
  import dacc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, add_valid, add_target, add_negate, add_zero;
  logic st_valid, st_target, st_round, sh_valid, sh_arith, xbus_wr_valid, sh_done, trap_req;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [39:0] add_operand, acc_a, acc_b, sh_result;
  logic [15:0] st_addr, sh_xdata, xbus_wr_addr, xbus_wr_data, wb_ptr, sh_word, m_addr, m_data;
  logic signed [4:0] sh_amount;
  logic signed [63:0] tmp;
  dacc_st_kind_t st_kind;
  dacc_sh_src_t sh_src;
  dacc_st_kind_t kinds [3] = '{DACC_ST_SAC, DACC_ST_WB_DIRECT, DACC_ST_WB_INDIRECT};
  dacc_sh_src_t srcs [3] = '{DACC_SH_ACC_A, DACC_SH_ACC_B, DACC_SH_XBUS};
  logic [15:0] lows [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0000};
  int m_count, n_errors = 0, samples_checked = 0, exp_count = 0;
  logic [39:0] m_acc [2] = '{default: '0};
  logic m_ov [2] = '{default: 1'b0};
  logic m_sat [2] = '{default: 1'b0};
  logic c_sat [2] = '{default: 1'b0};
  logic t_ov [2] = '{default: 1'b0};
  logic c_w40 = 1'b0, c_wsat = 1'b0, c_conv = 1'b0, t_cov = 1'b0;
  logic [15:0] m_wb = 16'h0;

  dacc_engine dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .add_valid(add_valid), .add_target(add_target),
    .add_operand(add_operand), .add_negate(add_negate), .add_zero(add_zero),
    .st_valid(st_valid), .st_kind(st_kind), .st_target(st_target), .st_round(st_round),
    .st_addr(st_addr), .sh_valid(sh_valid), .sh_src(sh_src), .sh_xdata(sh_xdata),
    .sh_amount(sh_amount), .sh_arith(sh_arith), .acc_a(acc_a), .acc_b(acc_b),
    .xbus_wr_valid(xbus_wr_valid), .xbus_wr_addr(xbus_wr_addr), .xbus_wr_data(xbus_wr_data),
    .wb_ptr(wb_ptr), .sh_done(sh_done), .sh_result(sh_result), .sh_word(sh_word),
    .trap_req(trap_req));
  dacc_xmem_model mem_u (.aclk(aclk), .aresetn(aresetn), .wr_valid(xbus_wr_valid),
    .wr_addr(xbus_wr_addr), .wr_data(xbus_wr_data), .last_addr(m_addr), .last_data(m_data),
    .wr_count(m_count));

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Valid and ready are sampled mid-cycle, so the handshake never races the design's edge
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    // Response ready stays up between writes, so no step lowers and raises it at once
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    chk(d, e);
    chk(r, er);
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    axi_wr(a, v, rs);
    chk(rs, RESP_OKAY);
    if (a == CONFIG_OFS) {c_sat[0], c_sat[1], c_wsat, c_w40} = v[7:4];
    if (a == CONFIG_OFS) c_conv = v[CFG_RND_BIT];
    if (a == TRAP_OFS) {t_cov, t_ov[1], t_ov[0]} = v[2:0];
    if (a == STATUS_OFS && v[ST_ACC_A_SAT_EN_BIT]) m_sat[0] = 1'b0;
    if (a == STATUS_OFS && v[ST_ACC_B_SAT_EN_BIT]) m_sat[1] = 1'b0;
  endtask

  task automatic add(input logic t, input logic [39:0] op, input logic ng, input logic z);
    logic [40:0] s;
    logic ovf;
    add_target <= t;
    add_operand <= op;
    add_negate <= ng;
    add_zero <= z;
    add_valid <= 1'b1;
    @(posedge aclk);
    add_valid <= 1'b0;
    s = (z ? 41'h0 : {m_acc[t][39], m_acc[t]}) + (ng ? -{op[39], op} : {op[39], op});
    ovf = (c_w40 || !c_sat[t]) ? s[40] != s[39] : s[40:31] != {10{s[40]}};
    m_acc[t] = s[39:0];
    if (c_sat[t] && ovf && c_w40) m_acc[t] = s[40] ? SAT40_NEG : SAT40_POS;
    if (c_sat[t] && ovf && !c_w40) m_acc[t] = s[40] ? SAT32_NEG : SAT32_POS;
    m_ov[t] = m_acc[t][39:31] != {9{m_acc[t][39]}};
    m_sat[t] = m_sat[t] | ovf;
    @(negedge aclk);
    chk(acc_a, m_acc[0]);
    chk(acc_b, m_acc[1]);
    @(posedge aclk);
    rd_chk(STATUS_OFS, {26'h0, m_sat[0] | m_sat[1], m_ov[0] | m_ov[1], m_sat[1], m_sat[0],
      m_ov[1], m_ov[0]}, RESP_OKAY);
    @(negedge aclk);
    chk(trap_req, (m_ov[0] & t_ov[0]) | (m_ov[1] & t_ov[1])
      | (t_cov & ((m_sat[0] & !c_sat[0]) | (m_sat[1] & !c_sat[1]))));
    @(posedge aclk);
  endtask

  function automatic logic [15:0] wword(input logic [39:0] a, input logic r);
    logic [23:0] v;
    v = a[39:16] + {23'h0, r && a[15] && !(c_conv && a[15:0] == HALF_LSW && !a[16])};
    if (c_wsat && !a[39] && v > 24'h007fff) return W_POS;
    if (c_wsat && a[39] && $signed(v) < $signed(24'hff8000)) return W_NEG;
    return v[15:0];
  endfunction

  task automatic store(input dacc_st_kind_t k, input logic t, input logic rn, input logic [15:0] a);
    logic [15:0] w, ea;
    st_kind <= k;
    st_target <= t;
    st_round <= rn;
    st_addr <= a;
    st_valid <= 1'b1;
    @(posedge aclk);
    st_valid <= 1'b0;
    w = (k == DACC_ST_SAC) ? wword(m_acc[t], rn) : wword(m_acc[!t], 1'b1);
    ea = (k == DACC_ST_SAC) ? a : m_wb;
    if (k == DACC_ST_WB_DIRECT) m_wb = w;
    else exp_count++;
    if (k == DACC_ST_WB_INDIRECT) m_wb = m_wb + WB_STEP;
    @(negedge aclk);
    chk(xbus_wr_valid, k != DACC_ST_WB_DIRECT);
    chk(wb_ptr, m_wb);
    chk(acc_a, m_acc[0]);
    chk(acc_b, m_acc[1]);
    @(posedge aclk);
    @(negedge aclk);
    chk(m_count, exp_count);
    if (k != DACC_ST_WB_DIRECT) chk({m_addr, m_data}, {ea, w});
    @(posedge aclk);
  endtask

  task automatic shift(input dacc_sh_src_t s, input logic signed [4:0] amt, input logic ar,
      input logic [15:0] x);
    int n;
    logic [39:0] op, r;
    logic [15:0] w;
    sh_src <= s;
    sh_amount <= amt;
    sh_arith <= ar;
    sh_xdata <= x;
    sh_valid <= 1'b1;
    @(posedge aclk);
    sh_valid <= 1'b0;
    n = amt;
    op = (s == DACC_SH_ACC_B) ? m_acc[1] : m_acc[0];
    if (n > 0) begin
      r = (op >> n) | (ar && op[39] ? ~(40'hffffffffff >> n) : 40'h0);
      w = (x >> n) | (ar && x[15] ? ~(16'hffff >> n) : 16'h0);
    end else begin
      r = op << -n;
      w = x << -n;
    end
    @(negedge aclk);
    chk(sh_done, 1'b1);
    if (s == DACC_SH_XBUS) chk(sh_word, w);
    else chk(sh_result, r);
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    #400000;
    n_errors++;
    summarize();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, add_valid, add_target} = '0;
    {add_negate, add_zero, st_valid, st_target, st_round, sh_valid, sh_arith} = '0;
    {awaddr, araddr, wdata, add_operand, st_addr, sh_xdata, sh_amount} = '0;
    wstrb = 4'hf;
    st_kind = DACC_ST_SAC;
    sh_src = DACC_SH_ACC_A;
    void'($urandom(89930));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(acc_a, 40'h0);
    chk(acc_b, 40'h0);
    chk(40'({wb_ptr, xbus_wr_valid, sh_done, trap_req}), 40'h0);
    @(posedge aclk);
    rd_chk(STATUS_OFS, 32'h0, RESP_OKAY);
    rd_chk(4'h2, 32'h0, RESP_SLVERR);
    axi_wr(4'h6, 32'hffffffff, rs);
    chk(rs, RESP_SLVERR);
    wr_reg(CONFIG_OFS, 32'hf2);
    rd_chk(CONFIG_OFS, 32'hf2, RESP_OKAY);
    wr_reg(WBPTR_OFS, 32'h1234);
    m_wb = 16'h1234;
    rd_chk(WBPTR_OFS, 32'h1234, RESP_OKAY);
    $display("test registers done");
    wr_reg(TRAP_OFS, 32'h7);
    wr_reg(CONFIG_OFS, 32'h80);
    add(1'b0, 40'h007fffffff, 1'b0, 1'b1);
    add(1'b0, 40'h1, 1'b0, 1'b0);
    add(1'b0, 40'h1, 1'b1, 1'b0);
    wr_reg(CONFIG_OFS, 32'h90);
    add(1'b0, 40'h7fffffffff, 1'b0, 1'b1);
    add(1'b0, 40'h1, 1'b0, 1'b0);
    wr_reg(CONFIG_OFS, 32'h0);
    add(1'b1, 40'h7fffffffff, 1'b0, 1'b1);
    add(1'b1, 40'h1, 1'b0, 1'b0);
    for (int i = 0; i < 240; i++) begin
      if (i % 16 == 0) wr_reg(CONFIG_OFS, $urandom & 32'hf2);
      if (i % 16 == 0) wr_reg(TRAP_OFS, $urandom & 32'h7);
      if (i % 40 == 39) wr_reg(STATUS_OFS, 32'hc);
      tmp = {$urandom, $urandom};
      tmp = tmp >>> ($urandom % 40);
      add(1'($urandom), tmp[39:0], 1'($urandom), i % 8 == 0);
    end
    $display("test adder and saturation done");
    for (int i = 0; i < 120; i++) begin
      if (i % 12 == 0) wr_reg(CONFIG_OFS, $urandom & 32'hf2);
      tmp = {$urandom, $urandom};
      tmp = tmp >>> ($urandom % 24);
      add(1'($urandom), {tmp[39:16], i % 5 == 4 ? 16'($urandom) : lows[i % 4]}, 1'b0, 1'b1);
      store(kinds[i % 3], 1'($urandom), 1'($urandom), 16'($urandom));
    end
    $display("test round and store done");
    for (int a = -16; a < 16; a++) begin
      for (int s = 0; s < 3; s++) begin
        shift(srcs[s], 5'(a), 1'($urandom), 16'($urandom));
      end
    end
    $display("test shifter done");
    summarize();
  end
endmodule // dacc_engine_tb_top
